// [pkg/capa_pkg.sv]
// Constants and carriers for the command/address parity and CRC alert block.
// Assumes one command clock; counts below are in those clock cycles.
package capa_pkg;

  // Clock period, picoseconds
  localparam int CLK_PERIOD_PS = 4000;

  // Command/address word carried with its parity bit
  localparam int CA_W = 24;

  // Parity latency, cycles
  localparam int PARITY_LATENCY = 4;

  // Parity alert onset allowance beyond parity_latency
  localparam int PAR_ALERT_EXTRA_PS = 6000;
  localparam int PAR_ALERT_EXTRA_CYC =
    (PAR_ALERT_EXTRA_PS / CLK_PERIOD_PS) < 1 ? 1 :
    (PAR_ALERT_EXTRA_PS / CLK_PERIOD_PS);

  // Parity alert pulse width limits, cycles
  localparam int PARITY_ALERT_PULSE_WIDTH_MIN = 56;
  localparam int PARITY_ALERT_PULSE_WIDTH_MAX = 128;

  // Controller deselect deadline in persistent mode, cycles
  localparam int DESELECT_RESPONSE_DEADLINE = 57;

  // CRC alert pulse width limits, cycles
  localparam int CRC_ALERT_PULSE_WIDTH_MIN = 6;
  localparam int CRC_ALERT_PULSE_WIDTH_MAX = 10;

  // CRC alert onset delay, least rounds up, longest rounds down
  localparam int CRC_ALERT_ONSET_MIN_PS = 3000;
  localparam int CRC_ALERT_ONSET_MAX_PS = 13000;
  localparam int CRC_ALERT_ONSET_MIN_CYC =
    (CRC_ALERT_ONSET_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CRC_ALERT_ONSET_MAX_CYC =
    (CRC_ALERT_ONSET_MAX_PS / CLK_PERIOD_PS) < 1 ? 1 :
    (CRC_ALERT_ONSET_MAX_PS / CLK_PERIOD_PS);

  // Width of the alert hold counters
  localparam int ALERT_CNT_W = 8;

  // Reset values
  localparam logic ALERT_OE_N_RST = 1'b1;
  localparam logic ALERT_PIN_LEVEL = 1'b0;

  // Command as it crosses the pins
  typedef struct packed {
    logic [CA_W-1:0] ca;
    logic par;
  } capa_cmd_s;

  // Command as it is handed to the core
  typedef struct packed {
    logic vld;
    logic [CA_W-1:0] ca;
  } capa_exec_s;

endpackage

// [src/capa_alert.sv]
// Command/address parity check, parity latency pipe and error alert driver.
// Assumes commands and CRC error strobes are synchronous to ref_clk_in.
`timescale 1ns/1ns
module capa_alert #(
  parameter int PL = capa_pkg::PARITY_LATENCY,
  parameter int PAR_HOLD = capa_pkg::PARITY_ALERT_PULSE_WIDTH_MIN,
  parameter int CRC_HOLD = 8
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // Mode straps
  input wire logic parity_en_in,
  input wire logic persistent_mode_in,
  // Command from the pins
  input wire logic cmd_vld_in,
  input wire capa_pkg::capa_cmd_s cmd_in,
  // Write CRC check result
  input wire logic crc_err_in,
  // Command to the core
  output capa_pkg::capa_exec_s exec_out,
  // Open-drain alert pin
  output logic alert_pin_out,
  output logic alert_oe_n_out
);

  localparam int CW = capa_pkg::ALERT_CNT_W;

  // Even parity over address and parity bit must be zero
  function automatic logic parity_bad(input capa_pkg::capa_cmd_s c);
    parity_bad = ^{c.ca, c.par};
  endfunction

  // Alert hold counter reload, never shortens a running alert
  function automatic logic [CW-1:0] reload(input logic [CW-1:0] cur,
                                           input logic [CW-1:0] val);
    reload = (val > cur) ? val : cur;
  endfunction

  logic check_on;
  logic cmd_err;
  logic cmd_ok;
  logic par_off_ff;
  logic [CW-1:0] par_cnt_ff;
  logic [CW-1:0] crc_cnt_ff;
  logic [CW-1:0] nxt_par_cnt;
  logic [CW-1:0] nxt_crc_cnt;
  capa_pkg::capa_exec_s pipe_ff [PL];

  // Non-persistent mode stops checking after the first error
  assign check_on = parity_en_in && !par_off_ff;
  assign cmd_err = cmd_vld_in && check_on && parity_bad(cmd_in);
  // Commands are ignored while a parity alert runs
  assign cmd_ok = cmd_vld_in && !cmd_err && (par_cnt_ff == '0);

  // Latch checking off after an error outside persistent mode
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || !parity_en_in) begin
      par_off_ff <= 1'b0;
    end else if (cmd_err && !persistent_mode_in) begin
      par_off_ff <= 1'b1;
    end
  end

  // Latency pipe; an error flushes it, so in-flight commands are lost
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || cmd_err) begin
      for (int i = 0; i < PL; i++) begin
        pipe_ff[i] <= '0;
      end
    end else begin
      pipe_ff[0].vld <= cmd_ok;
      pipe_ff[0].ca <= cmd_in.ca;
      for (int i = 1; i < PL; i++) begin
        pipe_ff[i] <= pipe_ff[i-1];
      end
    end
  end

  // Core hand-off: bypass pipe when parity_en_in is low
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || cmd_err) begin
      exec_out <= '0;
    end else if (parity_en_in) begin
      exec_out <= pipe_ff[PL-1];
    end else begin
      exec_out.vld <= cmd_ok;
      exec_out.ca <= cmd_in.ca;
    end
  end

  // Alert hold counters, each loaded by its own error source
  always_comb begin
    nxt_par_cnt = (par_cnt_ff != '0) ? par_cnt_ff - 1'b1 : '0;
    nxt_crc_cnt = (crc_cnt_ff != '0) ? crc_cnt_ff - 1'b1 : '0;
    if (cmd_err) begin
      nxt_par_cnt = reload(nxt_par_cnt, CW'(PAR_HOLD));
    end
    if (crc_err_in) begin
      nxt_crc_cnt = reload(nxt_crc_cnt, CW'(CRC_HOLD));
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      par_cnt_ff <= '0;
      crc_cnt_ff <= '0;
    end else begin
      par_cnt_ff <= nxt_par_cnt;
      crc_cnt_ff <= nxt_crc_cnt;
    end
  end

  // Pin driven low from the next edge: one cycle, well inside both windows
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      alert_oe_n_out <= capa_pkg::ALERT_OE_N_RST;
      alert_pin_out <= capa_pkg::ALERT_PIN_LEVEL;
    end else begin
      alert_oe_n_out <= !((nxt_par_cnt != '0) || (nxt_crc_cnt != '0));
      alert_pin_out <= capa_pkg::ALERT_PIN_LEVEL;
    end
  end

  // Checking helpers: low-run length and cause of the current alert
  // Bounds in edges, all derived from the shared timing constants
  localparam int EXEC_D = PL + 1;
  localparam int PAR_ON_D = PL + capa_pkg::PAR_ALERT_EXTRA_CYC;
  localparam int CRC_ON_MIN = capa_pkg::CRC_ALERT_ONSET_MIN_CYC;
  localparam int CRC_ON_MAX = capa_pkg::CRC_ALERT_ONSET_MAX_CYC;
  logic [CW:0] low_run_ff;
  logic par_seen_ff;

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || alert_oe_n_out) begin
      low_run_ff <= '0;
    end else if (low_run_ff != '1) begin
      low_run_ff <= low_run_ff + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      par_seen_ff <= 1'b0;
    end else if (cmd_err) begin
      par_seen_ff <= 1'b1;
    end else if (alert_oe_n_out) begin
      par_seen_ff <= 1'b0;
    end
  end

  // A checked command taken while no alert blocks the pipe
  sequence s_good_cmd;
    cmd_ok && parity_en_in && !cmd_err;
  endsequence

  // Quiet stretch that lets the command ripple through every stage
  sequence s_pipe_clear;
    (!cmd_err && parity_en_in) [*4];
  endsequence

  // Checked command comes out parity_latency edges late, intact
  property p_latency;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    s_good_cmd ##1 s_pipe_clear
      |-> ##1 (exec_out.vld && exec_out.ca == $past(cmd_in.ca, EXEC_D));
  endproperty
  a_latency: assert property (p_latency)
    else $error("Checked command not delivered after parity latency");

  // Unchecked command skips the pipe entirely
  property p_bypass;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (cmd_ok && !parity_en_in)
      |=> (exec_out.vld && exec_out.ca == $past(cmd_in.ca));
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("Unchecked command not delivered on the next cycle");

  // Onset bound rounds the extra allowance down, so it errs on the safe side
  property p_par_onset;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    cmd_err |-> ##[1:PAR_ON_D] !alert_oe_n_out;
  endproperty
  a_par_onset: assert property (p_par_onset)
    else $error("Alert late after parity error");

  // Width judged when the pin releases, by the cause seen in the episode
  property p_par_width;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    ($rose(alert_oe_n_out) && $past(par_seen_ff))
      |-> (low_run_ff >= capa_pkg::PARITY_ALERT_PULSE_WIDTH_MIN &&
           low_run_ff <= capa_pkg::PARITY_ALERT_PULSE_WIDTH_MAX);
  endproperty
  a_par_width: assert property (p_par_width)
    else $error("Parity alert width out of range");

  // A stuck alert never releases, so its length is bounded while still low
  property p_alert_bounded;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    !alert_oe_n_out
      |-> (low_run_ff < capa_pkg::PARITY_ALERT_PULSE_WIDTH_MAX);
  endproperty
  a_alert_bounded: assert property (p_alert_bounded)
    else $error("Alert held beyond the longest parity pulse");

  // CRC-only episodes must fit the short pulse window
  property p_crc_width;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    ($rose(alert_oe_n_out) && !$past(par_seen_ff))
      |-> (low_run_ff >= capa_pkg::CRC_ALERT_PULSE_WIDTH_MIN &&
           low_run_ff <= capa_pkg::CRC_ALERT_PULSE_WIDTH_MAX);
  endproperty
  a_crc_width: assert property (p_crc_width)
    else $error("CRC alert width out of range");

  // CRC onset measured in whole edges inside the allowed delay
  property p_crc_onset;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    crc_err_in |-> ##[CRC_ON_MIN:CRC_ON_MAX] !alert_oe_n_out;
  endproperty
  a_crc_onset: assert property (p_crc_onset)
    else $error("Alert late after CRC error");

  // Flush keeps commands already in flight from emerging after an error
  property p_no_exec;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    cmd_err |=> (!exec_out.vld) [*5];
  endproperty
  a_no_exec: assert property (p_no_exec)
    else $error("Command delivered despite parity error");

endmodule

// [verif/capa_ctrl_model.sv]
// Controller model on the command pins of the alert block.
// Assumes bench requests change just after rising edges.
`timescale 1ns/1ns
module capa_ctrl_model (
  // Bench requests
  input wire logic req_in,
  input wire logic bad_in,
  input wire logic [capa_pkg::CA_W-1:0] ca_in,
  // Alert seen from the device
  input wire logic alert_oe_n_in,
  // Command to the device
  output logic cmd_vld_out,
  output capa_pkg::capa_cmd_s cmd_out
);
  // Deselect at once while alert is low, well inside the deadline
  assign cmd_vld_out = req_in & alert_oe_n_in;
  // Even parity, flipped on demand; idle bus shows inverted pattern
  assign cmd_out = {(cmd_vld_out ? ca_in : ~ca_in), ^ca_in ^ bad_in};
endmodule

// [verif/capa_alert_tb_top.sv]
// Self-checking bench: random traffic, parity and CRC alert corners.
// Assumes the controller model drives the command pins.
`timescale 1ns/1ns
module capa_alert_tb_top;
  logic ref_clk_in = 0, sys_rst_in = 1, par_en = 0, req = 0, bad = 0;
  logic crc = 0, cmd_vld, oe_n, pin, saw_bad = 0, mon = 0, pers = 1;
  localparam int LAT = capa_pkg::PARITY_LATENCY;
  logic [23:0] ca = 24'h0, bad_ca = 24'hC3A55A;
  logic [24:0] hist [0:5];
  capa_pkg::capa_cmd_s cmd;
  capa_pkg::capa_exec_s exec;
  int errors = 0, n_compared = 0, seed = 49080, cyc = 0, on, w;
  // Clock, 4 ns period
  always #2 ref_clk_in = ~ref_clk_in;
  capa_ctrl_model i_capa_ctrl_model (.req_in(req), .bad_in(bad),
    .ca_in(ca), .alert_oe_n_in(oe_n), .cmd_vld_out(cmd_vld), .cmd_out(cmd));
  capa_alert i_capa_alert (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .parity_en_in(par_en), .persistent_mode_in(pers), .cmd_vld_in(cmd_vld),
    .cmd_in(cmd), .crc_err_in(crc), .exec_out(exec), .alert_pin_out(pin),
    .alert_oe_n_out(oe_n));
  task automatic chk(input logic [24:0] got, exp, input string m);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic rng(input int v, lo, hi, input string m);
    chk({24'h0, v >= lo && v <= hi}, 25'h1, m);
  endtask
  // Only a valid word carries a meaningful address
  function automatic logic [24:0] exp_exec(input logic [24:0] e);
    return e[24] ? e : 25'h0;
  endfunction
  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Command history and watchdog; checks land 1 ns after the edge
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc > 2000) begin
      errors++;
      final_report();
    end else begin
      hist[0] <= {cmd_vld, cmd.ca};
      for (int i = 1; i < 6; i++) hist[i] <= hist[i-1];
      if (exec.vld === 1'b1 && exec.ca === bad_ca) saw_bad <= 1'b1;
      #1;
      if (mon) chk({exec.vld, exec.vld ? exec.ca : 24'h0},
        exp_exec(par_en ? hist[LAT] : hist[0]), "exec");
    end
  end
  task automatic traffic(input logic pe);
    @(posedge ref_clk_in);
    par_en <= pe;
    repeat (8) @(posedge ref_clk_in);
    mon = 1;
    repeat (60) begin
      @(posedge ref_clk_in);
      req <= 1'($random(seed));
      ca <= 24'($random(seed));
    end
    @(posedge ref_clk_in);
    req <= 0;
    repeat (7) @(posedge ref_clk_in);
    mon = 0;
    $display("test traffic done");
  endtask
  // Onset counted from the edge that takes the cause
  task automatic measure(input int lo, hi, onmax, input string m);
    on = 1;
    w = 0;
    @(posedge ref_clk_in);
    req <= 0;
    bad <= 0;
    crc <= 0;
    #1;
    while (oe_n !== 1'b0 && on < 20) begin
      @(posedge ref_clk_in);
      #1 on++;
    end
    while (oe_n === 1'b0 && w < 200) begin
      w++;
      chk({24'h0, pin}, 25'h0, "pin level");
      @(posedge ref_clk_in);
      #1;
    end
    rng(on, 1, onmax, {m, " onset"});
    rng(w, lo, hi, {m, " width"});
    $display("test %s done", m);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk_in);
    sys_rst_in <= 0;
    #1;
    chk(exec, 25'h0, "reset exec");
    chk({24'h0, oe_n}, 25'h1, "reset alert");
    @(posedge ref_clk_in);
    #1;
    chk({24'h0, exec.vld}, 25'h0, "release exec");
    chk({24'h0, oe_n}, 25'h1, "release alert");
    $display("test reset done");
    traffic(1'b0);
    traffic(1'b1);
    repeat (2) begin
      @(posedge ref_clk_in);
      req <= 1;
      bad <= 1;
      ca <= bad_ca;
      measure(56, 128, 5, "parity");
    end
    chk({24'h0, saw_bad}, 25'h0, "errant command ran");
    repeat (3) begin
      repeat (1 + 3'($random(seed))) @(posedge ref_clk_in);
      crc <= 1;
      measure(6, 10, 3, "crc");
    end
    // Single-shot mode: checking stays off after the first error
    @(posedge ref_clk_in);
    pers <= 0;
    req <= 1;
    bad <= 1;
    ca <= bad_ca;
    measure(56, 128, 5, "single-shot");
    @(posedge ref_clk_in);
    req <= 1;
    bad <= 1;
    @(posedge ref_clk_in);
    req <= 0;
    bad <= 0;
    w = 0;
    repeat (8) begin
      @(posedge ref_clk_in);
      #1 if (oe_n !== 1'b1) w++;
    end
    rng(w, 0, 0, "latched check alert");
    $display("test latch done");
    final_report();
  end
endmodule
